/* File: design/rtb_defs.svh */
`ifndef RTB_DEFS_SVH
`define RTB_DEFS_SVH

// Register byte offsets
`define RTB_OFS_CTRL 8'h00
`define RTB_OFS_PROG 8'h04
`define RTB_OFS_BAR_CFG 8'h08
`define RTB_OFS_MTC_OFS 8'h0C
`define RTB_OFS_MTC_CFG 8'h10
`define RTB_OFS_TARGET 8'h14
`define RTB_OFS_CMD 8'h18
`define RTB_OFS_STATUS 8'h1C
`define RTB_OFS_ABS 8'h20
`define RTB_OFS_BAR 8'h24
`define RTB_OFS_CLK 8'h28
`define RTB_OFS_MTC 8'h2C

// Time field layout shared by offset, target and readback words
`define RTB_F_H_LSB 0
`define RTB_F_M_LSB 8
`define RTB_F_S_LSB 16
`define RTB_F_F_LSB 24
`define RTB_MTC_ANCHOR_BIT 8

// Reset values and bar offset limits
`define RTB_RST_BAR_OFS 4'h2
`define RTB_MIN_BAR_OFS 4'h2
`define RTB_MAX_BAR_OFS 4'h9
`define RTB_RST_BPB 4'h4
`define RTB_RST_FPB 16'h000F
`define RTB_RST_MTC_H 5'h00
`define RTB_RST_MTC_M 6'h3B
`define RTB_RST_MTC_S 6'h39

// Timing counts and program count
`define RTB_FPS 30
`define RTB_SEC_PER_MIN 60
`define RTB_MIN_PER_HR 60
`define RTB_HR_PER_DAY 24
`define RTB_SUBFRAMES 100
`define RTB_NUM_PROG 99

`endif

/* File: design/rtb_pkg.sv */
package rtb_pkg;

    typedef enum logic [1:0] {
        rtb_view_abs = 2'b00,
        rtb_view_bar = 2'b01,
        rtb_view_mtc = 2'b10
    } rtb_view_t;

    typedef enum logic [2:0] {
        rtb_seq_idle = 3'b000,
        rtb_seq_beat = 3'b001,
        rtb_seq_bar = 3'b010,
        rtb_seq_msec = 3'b011,
        rtb_seq_mmin = 3'b100,
        rtb_seq_mhr = 3'b101
    } rtb_seq_t;

    typedef struct packed {
        logic [4:0] h;
        logic [5:0] m;
        logic [5:0] s;
        logic [4:0] f;
    } rtb_hmsf_t;

    // One program's counter and time base settings
    typedef struct packed {
        rtb_hmsf_t pos;
        logic [3:0] bar_ofs;
        logic [3:0] bpb;
        logic [15:0] fpb;
        rtb_hmsf_t mtc_ofs;
        logic [6:0] mtc_sf;
        logic anchor_bar1;
    } rtb_prog_t;

endpackage

/* File: design/rtb_div_if.sv */
interface rtb_div_if #(
    parameter int W = 24
);
    logic start;
    logic [W-1:0] dividend;
    logic [W-1:0] divisor;
    logic done;
    logic [W-1:0] quot;
    logic [W-1:0] rem;

    modport req (output start, output dividend, output divisor,
                 input done, input quot, input rem);
    modport srv (input start, input dividend, input divisor,
                 output done, output quot, output rem);
endinterface

/* File: design/rtb_divider.sv */
module rtb_divider #(
    parameter int W = 24
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Divide request
    rtb_div_if.srv div
);
    localparam int CW = $clog2(W + 1);

    typedef struct packed {
        logic busy;
        logic done;
        logic [CW-1:0] cnt;
        logic [W-1:0] q;
        logic [W:0] r;
        logic [W-1:0] d;
    } rtb_div_state_t;

    rtb_div_state_t st_r;
    rtb_div_state_t st_nxt;
    logic [W:0] sh;

    // Restoring divide, one quotient bit a cycle; W cycles keeps area small
    always_comb begin
        sh = {st_r.r[W-1:0], st_r.q[W-1]};
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (!st_r.busy) begin
            if (div.start) begin
                st_nxt.busy = 1'b1;
                st_nxt.q = div.dividend;
                st_nxt.r = '0;
                st_nxt.d = div.divisor;
                st_nxt.cnt = CW'(W);
            end
        end else begin
            st_nxt.q = {st_r.q[W-2:0], 1'b0};
            if (sh >= {1'b0, st_r.d}) begin
                st_nxt.r = sh - {1'b0, st_r.d};
                st_nxt.q[0] = 1'b1;
            end else begin
                st_nxt.r = sh;
            end
            st_nxt.cnt = st_r.cnt - CW'(1);
            if (st_r.cnt == CW'(1)) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign div.done = st_r.done;
    assign div.quot = st_r.q;
    assign div.rem = st_r.r[W-1:0];
endmodule

/* File: design/rtb_time_base_locator.sv */
`include "rtb_defs.svh"

module rtb_time_base_locator #(
    parameter int NUM_PROG = `RTB_NUM_PROG,
    parameter int FPS = `RTB_FPS,
    parameter int DIV_W = 24
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Disk recorder position
    input wire logic i_frame_tick,
    output logic o_locate,
    output logic o_rec_start,
    output logic [21:0] o_locate_pos,
    // Front panel keys
    input wire logic i_shift_key,
    input wire logic i_display_select_key,
    // Time display
    output logic [1:0] o_view,
    output logic o_disp_hours_en,
    output logic [15:0] o_disp_f0,
    output logic [7:0] o_disp_f1,
    output logic [7:0] o_disp_f2,
    output logic [7:0] o_disp_f3,
    output logic [7:0] o_disp_f4
);
    localparam int PW = $clog2(NUM_PROG);
    localparam int SW = DIV_W + 2;
    localparam logic [SW-1:0] DAY_FRAMES =
        SW'(`RTB_HR_PER_DAY * `RTB_MIN_PER_HR * `RTB_SEC_PER_MIN * FPS);

    generate
        if (NUM_PROG < 2 || NUM_PROG > 128 || FPS < 2 || FPS > 32 || DIV_W < 23) begin : g_chk
            $error("rtb_time_base_locator: unsupported parameter values");
        end
    endgenerate

    localparam rtb_pkg::rtb_prog_t PROG_RST = '{
        pos: '0,
        bar_ofs: `RTB_RST_BAR_OFS,
        bpb: `RTB_RST_BPB,
        fpb: `RTB_RST_FPB,
        mtc_ofs: '{h: `RTB_RST_MTC_H, m: `RTB_RST_MTC_M, s: `RTB_RST_MTC_S, f: 5'h00},
        mtc_sf: 7'h00,
        anchor_bar1: 1'b0
    };

    typedef struct packed {
        rtb_pkg::rtb_prog_t [NUM_PROG-1:0] prog;
        logic [PW-1:0] sel;
        rtb_pkg::rtb_view_t view;
        logic [1:0] shift_sync;
        logic [1:0] key_sync;
        logic key_prev;
        rtb_pkg::rtb_hmsf_t target;
        logic loc_err;
        logic rec_err;
        logic loc_pulse;
        logic rec_pulse;
        rtb_pkg::rtb_seq_t seq;
        logic issued;
        logic [DIV_W-1:0] snap_f;
        logic [DIV_W-1:0] snap_m;
        logic [DIV_W-1:0] tmp;
        logic [15:0] bar;
        logic [3:0] beat;
        logic [15:0] clk;
        rtb_pkg::rtb_hmsf_t mtc;
        logic [31:0] prdata;
        logic pslverr;
        logic [15:0] d0;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] d3;
        logic [7:0] d4;
        logic hours_en;
    } rtb_state_t;

    rtb_state_t st_r;
    rtb_state_t st_nxt;
    rtb_pkg::rtb_prog_t cur;
    logic [SW-1:0] mtc_sum;
    logic [SW-1:0] anchor;
    logic signed [15:0] bar_val;
    logic wr_acc;
    logic key_hit;

    rtb_div_if #(.W(DIV_W)) div ();

    rtb_divider #(.W(DIV_W)) u_div (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .div(div.srv)
    );

    function automatic logic hmsf_ok(input rtb_pkg::rtb_hmsf_t x);
        return (32'(x.h) < `RTB_HR_PER_DAY) && (32'(x.m) < `RTB_MIN_PER_HR) &&
               (32'(x.s) < `RTB_SEC_PER_MIN) && (32'(x.f) < FPS);
    endfunction

    function automatic logic [DIV_W-1:0] to_frames(input rtb_pkg::rtb_hmsf_t x);
        logic [DIV_W-1:0] acc;
        acc = DIV_W'(x.h);
        acc = acc * DIV_W'(`RTB_MIN_PER_HR) + DIV_W'(x.m);
        acc = acc * DIV_W'(`RTB_SEC_PER_MIN) + DIV_W'(x.s);
        acc = acc * DIV_W'(FPS) + DIV_W'(x.f);
        return acc;
    endfunction

    function automatic rtb_pkg::rtb_hmsf_t word_to_hmsf(input logic [31:0] w);
        rtb_pkg::rtb_hmsf_t y;
        y.h = w[`RTB_F_H_LSB +: 5];
        y.m = w[`RTB_F_M_LSB +: 6];
        y.s = w[`RTB_F_S_LSB +: 6];
        y.f = w[`RTB_F_F_LSB +: 5];
        return y;
    endfunction

    function automatic logic [31:0] hmsf_to_word(input rtb_pkg::rtb_hmsf_t x);
        logic [31:0] w;
        w = '0;
        w[`RTB_F_H_LSB +: 5] = x.h;
        w[`RTB_F_M_LSB +: 6] = x.m;
        w[`RTB_F_S_LSB +: 6] = x.s;
        w[`RTB_F_F_LSB +: 5] = x.f;
        return w;
    endfunction

    // Counter stops at 23:59:59 last frame; the disk has no time beyond it
    function automatic rtb_pkg::rtb_hmsf_t inc_hmsf(input rtb_pkg::rtb_hmsf_t x);
        rtb_pkg::rtb_hmsf_t y;
        y = x;
        if (32'(x.f) < FPS - 1) begin
            y.f = x.f + 5'h01;
        end else if (32'(x.s) < `RTB_SEC_PER_MIN - 1) begin
            y.f = 5'h00;
            y.s = x.s + 6'h01;
        end else if (32'(x.m) < `RTB_MIN_PER_HR - 1) begin
            y.f = 5'h00;
            y.s = 6'h00;
            y.m = x.m + 6'h01;
        end else if (32'(x.h) < `RTB_HR_PER_DAY - 1) begin
            y = '0;
            y.h = x.h + 5'h01;
        end
        return y;
    endfunction

    assign cur = st_r.prog[st_r.sel];
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign key_hit = st_r.key_sync[1] && !st_r.key_prev && st_r.shift_sync[1];

    // Frame count at which bar 001 beat 1 falls
    assign anchor = cur.anchor_bar1 ?
        SW'(cur.bar_ofs) * SW'(cur.bpb) * SW'(cur.fpb) : '0;

    always_comb begin
        mtc_sum = SW'(to_frames(cur.pos)) + SW'(to_frames(cur.mtc_ofs)) - anchor;
        if (mtc_sum[SW-1]) begin
            mtc_sum = mtc_sum + DAY_FRAMES;
        end
        if (mtc_sum >= DAY_FRAMES) begin
            mtc_sum = mtc_sum - DAY_FRAMES;
        end
        if (mtc_sum >= DAY_FRAMES) begin
            mtc_sum = mtc_sum - DAY_FRAMES;
        end
    end

    always_comb begin
        bar_val = $signed({1'b0, div.quot[14:0]}) - $signed({12'h000, cur.bar_ofs});
        if (bar_val >= 16'sh0000) begin
            bar_val = bar_val + 16'sh0001;
        end
    end

    // Divider request follows the sequencer state
    always_comb begin
        div.start = (st_r.seq != rtb_pkg::rtb_seq_idle) && !st_r.issued;
        case (st_r.seq)
            rtb_pkg::rtb_seq_beat: begin
                div.dividend = st_r.snap_f;
                div.divisor = DIV_W'(cur.fpb);
            end
            rtb_pkg::rtb_seq_bar: begin
                div.dividend = st_r.tmp;
                div.divisor = DIV_W'(cur.bpb);
            end
            rtb_pkg::rtb_seq_msec: begin
                div.dividend = st_r.snap_m;
                div.divisor = DIV_W'(FPS);
            end
            rtb_pkg::rtb_seq_mmin: begin
                div.dividend = st_r.tmp;
                div.divisor = DIV_W'(`RTB_SEC_PER_MIN);
            end
            rtb_pkg::rtb_seq_mhr: begin
                div.dividend = st_r.tmp;
                div.divisor = DIV_W'(`RTB_MIN_PER_HR);
            end
            default: begin
                div.dividend = '0;
                div.divisor = DIV_W'(1);
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.loc_pulse = 1'b0;
        st_nxt.rec_pulse = 1'b0;
        st_nxt.shift_sync = {st_r.shift_sync[0], i_shift_key};
        st_nxt.key_sync = {st_r.key_sync[0], i_display_select_key};
        st_nxt.key_prev = st_r.key_sync[1];

        if (key_hit) begin
            case (st_r.view)
                rtb_pkg::rtb_view_abs: st_nxt.view = rtb_pkg::rtb_view_bar;
                rtb_pkg::rtb_view_bar: st_nxt.view = rtb_pkg::rtb_view_mtc;
                default: st_nxt.view = rtb_pkg::rtb_view_abs;
            endcase
        end

        if (i_frame_tick) begin
            st_nxt.prog[st_r.sel].pos = inc_hmsf(cur.pos);
        end

        // Setup phase: latch read data and error so they come from flops
        if (i_psel && !i_penable) begin
            st_nxt.prdata = '0;
            st_nxt.pslverr = 1'b0;
            case (i_paddr)
                `RTB_OFS_CTRL: st_nxt.prdata[1:0] = st_r.view;
                `RTB_OFS_PROG: st_nxt.prdata[PW-1:0] = st_r.sel;
                `RTB_OFS_BAR_CFG: begin
                    st_nxt.prdata = {cur.fpb, 8'h00, cur.bpb, cur.bar_ofs};
                    if (i_pwrite && (i_pwdata[3:0] < `RTB_MIN_BAR_OFS ||
                        i_pwdata[3:0] > `RTB_MAX_BAR_OFS || i_pwdata[7:4] == 4'h0 ||
                        i_pwdata[31:16] == 16'h0000)) begin
                        st_nxt.pslverr = 1'b1;
                    end
                end
                `RTB_OFS_MTC_OFS: begin
                    st_nxt.prdata = hmsf_to_word(cur.mtc_ofs);
                    st_nxt.pslverr = i_pwrite && !hmsf_ok(word_to_hmsf(i_pwdata));
                end
                `RTB_OFS_MTC_CFG: begin
                    st_nxt.prdata = {23'h000000, cur.anchor_bar1, 1'b0, cur.mtc_sf};
                    st_nxt.pslverr = i_pwrite && (32'(i_pwdata[6:0]) >= `RTB_SUBFRAMES);
                end
                `RTB_OFS_TARGET: st_nxt.prdata = hmsf_to_word(st_r.target);
                `RTB_OFS_CMD: st_nxt.prdata = '0;
                `RTB_OFS_STATUS: begin
                    st_nxt.prdata[0] = st_r.loc_err;
                    st_nxt.prdata[1] = st_r.rec_err;
                    st_nxt.prdata[2] = st_r.seq != rtb_pkg::rtb_seq_idle;
                    st_nxt.prdata[4] = st_r.hours_en;
                end
                `RTB_OFS_ABS: st_nxt.prdata = hmsf_to_word(cur.pos);
                `RTB_OFS_BAR: st_nxt.prdata = {12'h000, st_r.beat, st_r.bar};
                `RTB_OFS_CLK: st_nxt.prdata = {16'h0000, st_r.clk};
                `RTB_OFS_MTC: st_nxt.prdata = hmsf_to_word(st_r.mtc);
                default: st_nxt.pslverr = 1'b1;
            endcase
        end

        // Access phase: writes take effect here
        if (wr_acc && !st_r.pslverr) begin
            case (i_paddr)
                `RTB_OFS_CTRL: begin
                    if (i_pwdata[1:0] != 2'b11) begin
                        st_nxt.view = rtb_pkg::rtb_view_t'(i_pwdata[1:0]);
                    end
                end
                `RTB_OFS_PROG: begin
                    if (32'(i_pwdata[6:0]) < NUM_PROG) begin
                        st_nxt.sel = PW'(i_pwdata[6:0]);
                    end
                end
                `RTB_OFS_BAR_CFG: begin
                    st_nxt.prog[st_r.sel].bar_ofs = i_pwdata[3:0];
                    st_nxt.prog[st_r.sel].bpb = i_pwdata[7:4];
                    st_nxt.prog[st_r.sel].fpb = i_pwdata[31:16];
                end
                `RTB_OFS_MTC_OFS: begin
                    st_nxt.prog[st_r.sel].mtc_ofs = word_to_hmsf(i_pwdata);
                end
                `RTB_OFS_MTC_CFG: begin
                    st_nxt.prog[st_r.sel].mtc_sf = i_pwdata[6:0];
                    st_nxt.prog[st_r.sel].anchor_bar1 = i_pwdata[`RTB_MTC_ANCHOR_BIT];
                end
                `RTB_OFS_TARGET: st_nxt.target = word_to_hmsf(i_pwdata);
                `RTB_OFS_STATUS: begin
                    st_nxt.loc_err = st_r.loc_err && !i_pwdata[0];
                    st_nxt.rec_err = st_r.rec_err && !i_pwdata[1];
                end
                `RTB_OFS_CMD: begin
                    if (i_pwdata[0] || i_pwdata[1]) begin
                        if (hmsf_ok(st_r.target)) begin
                            st_nxt.prog[st_r.sel].pos = st_r.target;
                            st_nxt.loc_pulse = i_pwdata[0];
                            st_nxt.rec_pulse = i_pwdata[1];
                        end else begin
                            st_nxt.loc_err = st_r.loc_err || i_pwdata[0];
                            st_nxt.rec_err = st_r.rec_err || i_pwdata[1];
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Views are refreshed by a loop of five divides over one snapshot
        if (div.start) begin
            st_nxt.issued = 1'b1;
        end
        case (st_r.seq)
            rtb_pkg::rtb_seq_idle: begin
                st_nxt.snap_f = to_frames(cur.pos);
                st_nxt.snap_m = mtc_sum[DIV_W-1:0];
                st_nxt.seq = rtb_pkg::rtb_seq_beat;
                st_nxt.issued = 1'b0;
                st_nxt.hours_en = cur.pos.h != 5'h00;
                case (st_r.view)
                    rtb_pkg::rtb_view_bar: begin
                        st_nxt.d0 = st_r.bar;
                        st_nxt.d1 = {4'h0, st_r.beat};
                        st_nxt.d2 = st_r.clk[15:8];
                        st_nxt.d3 = st_r.clk[7:0];
                        st_nxt.d4 = 8'h00;
                    end
                    rtb_pkg::rtb_view_mtc: begin
                        st_nxt.d0 = {11'h000, st_r.mtc.h};
                        st_nxt.d1 = {2'h0, st_r.mtc.m};
                        st_nxt.d2 = {2'h0, st_r.mtc.s};
                        st_nxt.d3 = {3'h0, st_r.mtc.f};
                        st_nxt.d4 = {1'b0, cur.mtc_sf};
                    end
                    default: begin
                        st_nxt.d0 = (cur.pos.h != 5'h00) ? {11'h000, cur.pos.h} : 16'h0000;
                        st_nxt.d1 = {2'h0, cur.pos.m};
                        st_nxt.d2 = {2'h0, cur.pos.s};
                        st_nxt.d3 = {3'h0, cur.pos.f};
                        st_nxt.d4 = 8'h00;
                    end
                endcase
            end
            rtb_pkg::rtb_seq_beat: begin
                if (st_r.issued && div.done) begin
                    st_nxt.tmp = div.quot;
                    st_nxt.clk = div.rem[15:0];
                    st_nxt.issued = 1'b0;
                    st_nxt.seq = rtb_pkg::rtb_seq_bar;
                end
            end
            rtb_pkg::rtb_seq_bar: begin
                if (st_r.issued && div.done) begin
                    st_nxt.bar = bar_val;
                    st_nxt.beat = div.rem[3:0] + 4'h1;
                    st_nxt.issued = 1'b0;
                    st_nxt.seq = rtb_pkg::rtb_seq_msec;
                end
            end
            rtb_pkg::rtb_seq_msec: begin
                if (st_r.issued && div.done) begin
                    st_nxt.tmp = div.quot;
                    st_nxt.mtc.f = div.rem[4:0];
                    st_nxt.issued = 1'b0;
                    st_nxt.seq = rtb_pkg::rtb_seq_mmin;
                end
            end
            rtb_pkg::rtb_seq_mmin: begin
                if (st_r.issued && div.done) begin
                    st_nxt.tmp = div.quot;
                    st_nxt.mtc.s = div.rem[5:0];
                    st_nxt.issued = 1'b0;
                    st_nxt.seq = rtb_pkg::rtb_seq_mhr;
                end
            end
            rtb_pkg::rtb_seq_mhr: begin
                if (st_r.issued && div.done) begin
                    st_nxt.mtc.h = div.quot[4:0];
                    st_nxt.mtc.m = div.rem[5:0];
                    st_nxt.issued = 1'b0;
                    st_nxt.seq = rtb_pkg::rtb_seq_idle;
                end
            end
            default: st_nxt.seq = rtb_pkg::rtb_seq_idle;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= '0;
            st_r.prog <= {NUM_PROG{PROG_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Zero-wait slave: data was latched in the setup cycle
    assign o_pready = i_psel && i_penable;
    assign o_prdata = st_r.prdata;
    assign o_pslverr = st_r.pslverr;
    assign o_locate = st_r.loc_pulse;
    assign o_rec_start = st_r.rec_pulse;
    assign o_locate_pos = cur.pos;
    assign o_view = st_r.view;
    assign o_disp_hours_en = st_r.hours_en;
    assign o_disp_f0 = st_r.d0;
    assign o_disp_f1 = st_r.d1;
    assign o_disp_f2 = st_r.d2;
    assign o_disp_f3 = st_r.d3;
    assign o_disp_f4 = st_r.d4;
endmodule

/* File: bench/rtb_panel.sv */
module rtb_panel (
    // Clock and press request
    input wire logic i_core_clk,
    input wire logic i_press,
    // Key pins
    output logic o_shift_key,
    output logic o_display_select_key
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] step_r = 5'h0;
    always @(posedge i_core_clk) begin
        if (i_press || step_r != 5'h0) begin
            step_r <= step_r + 5'h1;
        end
    end
    // Shift wraps the select press so the synchroniser sees it held
    assign o_shift_key = step_r != 5'h0;
    assign o_display_select_key = step_r > 5'h5 && step_r < 5'hC;
endmodule

/* File: bench/rtb_assertions.sv */
module rtb_assertions (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Bus and keys
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_frame_tick,
    input wire logic i_shift_key,
    // Outputs watched
    input wire logic o_pslverr,
    input wire logic o_locate,
    input wire logic o_rec_start,
    input wire logic [21:0] o_locate_pos,
    input wire logic [1:0] o_view
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    wire wr_acc = i_psel && i_penable && i_pwrite;
    a_view_legal: assert property (o_view != 2'h3) else $error("bad view");
    a_view_step: assert property ($changed(o_view) |-> $past(i_shift_key, 3) || $past(i_psel))
        else $error("view moved alone");
    a_pos_hold: assert property (!$past(i_frame_tick) && !$past(i_frame_tick, 2)
        && !$past(i_psel) && !$past(i_psel, 2) |-> $stable(o_locate_pos)) else $error("pos moved");
    a_frame_step: assert property (i_frame_tick && !i_psel && o_locate_pos[4:0] == 5'h3
        |-> ##[1:2] o_locate_pos[4:0] == 5'h4) else $error("tick lost");
    a_locate_cause: assert property (o_locate |-> $past(wr_acc && i_paddr == 8'h18
        && i_pwdata[0])) else $error("stray locate");
    a_rec_cause: assert property (o_rec_start |-> $past(wr_acc && i_paddr == 8'h18
        && i_pwdata[1])) else $error("stray record");
    a_pulse_once: assert property (o_locate || o_rec_start |=> !o_locate && !o_rec_start)
        else $error("long pulse");
    a_bar_range: assert property (wr_acc && i_paddr == 8'h08
        && (i_pwdata[3:0] > 4'h9 || i_pwdata[3:0] < 4'h2) |-> o_pslverr) else $error("bar taken");
    a_mtc_range: assert property (wr_acc && i_paddr == 8'h0C && i_pwdata[4:0] > 5'h17
        |-> o_pslverr) else $error("offset taken");
    c_locate: cover property (o_locate);
    c_record: cover property (o_rec_start);
    c_view_mtc: cover property ($changed(o_view) && o_view == 2'h2);
endmodule

/* File: bench/testbench.sv */
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("unexpected %0t %h %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, tick = 1'b0, press = 1'b0;
    logic [7:0] pa = 8'h0;
    logic [31:0] pd = 32'h0, prd, q;
    logic rdy, err, e, sh, ds, loc, rec, hrs;
    logic [21:0] pos;
    logic [1:0] view;
    wire [47:0] disp;
    int errors = 0, comparisons = 0;
    always #5 clk = ~clk;
    rtb_time_base_locator i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pd), .o_prdata(prd),
        .o_pready(rdy), .o_pslverr(err), .i_frame_tick(tick), .o_locate(loc),
        .o_rec_start(rec), .o_locate_pos(pos), .i_shift_key(sh), .i_display_select_key(ds),
        .o_view(view), .o_disp_hours_en(hrs), .o_disp_f0(disp[47:32]),
        .o_disp_f1(disp[31:24]), .o_disp_f2(disp[23:16]), .o_disp_f3(disp[15:8]),
        .o_disp_f4(disp[7:0]));
    rtb_panel i_panel (.i_core_clk(clk), .i_press(press), .o_shift_key(sh),
        .o_display_select_key(ds));
    task automatic end_of_test();
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 16);
        q = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 16) begin
            errors++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
        apb(1'b1, a, d);
        `CHK(e, x)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask
    task automatic t_defaults();
        repeat (300) @(posedge clk);
        rd(8'h08, 32'h000F0042);
        rd(8'h0C, 32'h00393B00);
        rd(8'h24, 32'h0001FFFE);
    endtask
    task automatic t_refuse();
        wr(8'h08, 32'h000F004A, 1'b1);
        wr(8'h08, 32'h000F0041, 1'b1);
        wr(8'h08, 32'h000F0049, 1'b0);
        rd(8'h08, 32'h000F0049);
        wr(8'h08, 32'h000F0042, 1'b0);
        wr(8'h0C, 32'h00000018, 1'b1);
        rd(8'h30, 32'h0);
        wr(8'h00, 32'h3, 1'b0);
        `CHK(view, 2'h0)
    endtask
    task automatic t_view();
        for (int i = 1; i < 4; i++) begin
            @(posedge clk);
            press <= 1'b1;
            @(posedge clk);
            press <= 1'b0;
            repeat (40) @(posedge clk);
            `CHK(view, 2'(i % 3))
        end
    endtask
    task automatic t_ticks();
        repeat (5) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        rd(8'h20, 32'h05000000);
        repeat (300) @(posedge clk);
        rd(8'h2C, 32'h05393B00);
        `CHK(hrs, 1'b0)
        `CHK(disp, 48'h000000000500)
        wr(8'h0C, 32'h1D3B3B17, 1'b0);
        repeat (300) @(posedge clk);
        rd(8'h2C, 32'h04000000);
    endtask
    task automatic t_locate();
        wr(8'h14, 32'h00000018, 1'b0);
        wr(8'h18, 32'h1, 1'b0);
        #1 `CHK(loc, 1'b0)
        apb(1'b0, 8'h1C, 32'h0);
        `CHK(q[1:0], 2'h1)
        wr(8'h1C, 32'h1, 1'b0);
        wr(8'h14, 32'h00000001, 1'b0);
        wr(8'h18, 32'h1, 1'b0);
        #1 `CHK(loc, 1'b1)
        wr(8'h18, 32'h2, 1'b0);
        #1 `CHK({rec, loc, pos}, {2'h2, 22'h020000})
        apb(1'b0, 8'h1C, 32'h0);
        `CHK(q[1:0], 2'h0)
        repeat (300) @(posedge clk);
        `CHK(hrs, 1'b1)
        wr(8'h04, 32'h1, 1'b0);
        rd(8'h20, 32'h0);
        wr(8'h04, 32'h0, 1'b0);
        wr(8'h04, 32'h63, 1'b0);
        rd(8'h04, 32'h0);
        rd(8'h20, 32'h00000001);
    endtask
    // Position 01:00:00:00 is 108000 frames; 7 frames a beat, 5 beats a bar, offset -003
    task automatic t_tempo();
        wr(8'h08, 32'h00070053, 1'b0);
        wr(8'h10, 32'h00000105, 1'b0);
        repeat (300) @(posedge clk);
        `CHK(disp, 48'h000100000000)
        rd(8'h24, 32'h00040C0B);
        rd(8'h28, 32'h00000004);
        rd(8'h2C, 32'h0E383B00);
        wr(8'h00, 32'h1, 1'b0);
        repeat (300) @(posedge clk);
        `CHK(disp, 48'h0C0B04000400)
        wr(8'h00, 32'h2, 1'b0);
        repeat (300) @(posedge clk);
        `CHK(disp, 48'h00003B380E05)
        wr(8'h04, 32'h1, 1'b0);
        rd(8'h08, 32'h000F0042);
        wr(8'h04, 32'h0, 1'b0);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_defaults();
        t_refuse();
        t_view();
        t_ticks();
        t_locate();
        t_tempo();
        end_of_test();
    end
endmodule
bind rtb_time_base_locator rtb_assertions i_chk (.*);
